// file: verilog/pmm_top.sv
// module: power monitor min/max, power and shutdown logic on ahb-lite
`timescale 1ns/1ps
module pmm_top (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        vdd_uvlo_ok,
  input  wire logic        internal_low_voltage_supply_uvlo_ok,
  input  wire logic        vdd_i2c_ok,
  input  wire logic        internal_low_voltage_supply_i2c_ok,
  input  wire logic [1:0]  addr_select_pin_hi,
  input  wire logic [1:0]  addr_select_pin_lo,
  input  wire logic        adc_done,
  input  wire logic [11:0] adc_code,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             adc_enable,
  output logic             adc_start,
  output logic      [1:0]  adc_chan,
  output logic             ref_enable,
  output logic             regulator_enable,
  output logic             iface_rst,
  output logic      [7:0]  bus_address,
  output logic      [9:0]  limit_status
);
  pmm_pkg::pmm_chan_t  ch [3];
  pmm_pkg::pmm_state_t state;
  logic [7:0]  ctrl;
  logic [23:0] power;
  logic [23:0] pmax;
  logic [23:0] pmin;
  logic [23:0] pthmax;
  logic [23:0] pthmin;
  logic [3:0]  addr_latch;
  logic [1:0]  s1_sup;
  logic [1:0]  s2_sup;
  logic [1:0]  s1_rst;
  logic [1:0]  s2_rst;
  logic [7:0]  s1_adr;
  logic [7:0]  s2_adr;
  logic        s1_done;
  logic        s2_done;
  logic        s3_done;
  logic [11:0] s1_code;
  logic [11:0] code_q;
  logic        done_q;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic [1:0]  cur_ch;
  logic        snap_go;
  logic        shdn;
  logic [1:0]  vsel;
  logic        wr_en;
  logic [7:0]  rd_addr;
  logic [31:0] hrdata_c;
  logic [23:0] next_power;
  // unsigned compare of two codes
  function automatic logic lt12(input logic [11:0] a, input logic [11:0] b);
    lt12 = a < b;
  endfunction
  // byte-offset decode into a channel register window
  function automatic logic hit(input logic [7:0] a, input int c,
                               input logic [7:0] sub);
    hit = a == 8'(pmm_pkg::chan_base + 8'(c) * pmm_pkg::chan_stride + sub);
  endfunction
  // supply and address pin inputs synchronised
  always_ff @(posedge clk) begin
    s1_sup  <= {vdd_uvlo_ok, internal_low_voltage_supply_uvlo_ok};
    s2_sup  <= s1_sup;
    s1_rst  <= {vdd_i2c_ok, internal_low_voltage_supply_i2c_ok};
    s2_rst  <= s1_rst;
    s1_adr  <= {4'h0, addr_select_pin_hi, addr_select_pin_lo};
    s2_adr  <= s1_adr;
  end
  // converter handshake: done held high ends only one conversion
  always_ff @(posedge clk) begin
    s1_done <= adc_done;
    s2_done <= s1_done;
    s3_done <= s2_done;
    s1_code <= adc_code;
    code_q  <= s1_code;
    done_q  <= s2_done & ~s3_done;
  end
  assign shdn  = ctrl[pmm_pkg::shdn_pos];
  assign vsel  = {ctrl[pmm_pkg::sel_hi_pos], ctrl[pmm_pkg::sel_lo_pos]};
  // write data lands one edge after its address phase
  assign wr_en = wr_pend;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      adc_enable <= 1'b0;
      iface_rst  <= 1'b1;
    end else begin
      adc_enable <= (|s2_sup) & ~shdn;
      iface_rst  <= ~(|s2_rst);
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ref_enable       <= 1'b0;
      regulator_enable <= 1'b0;
    end else begin
      ref_enable       <= ~shdn;
      regulator_enable <= ~shdn;
    end
  end
  // address pins sampled only outside shutdown
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_latch  <= 4'h0;
      bus_address <= 8'h00;
    end else begin
      if (!shdn) begin
        addr_latch <= s2_adr[3:0];
      end
      bus_address <= {4'h0, addr_latch};
    end
  end
  // ahb-lite address phase capture, zero wait states
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= hsel & hready & htrans[1] & hwrite;
      if (hsel & hready & htrans[1]) begin
        wr_addr <= haddr[7:0];
      end
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  // conversion sequencer: continuous runs the fixed order,
  // snapshot waits for a request
  always_ff @(posedge clk) begin
    if (sys_rst || iface_rst) begin
      state     <= pmm_pkg::pmm_idle;
      cur_ch    <= pmm_pkg::ch_sense;
      adc_start <= 1'b0;
      adc_chan  <= pmm_pkg::ch_sense;
    end else begin
      adc_start <= 1'b0;
      case (state)
        pmm_pkg::pmm_idle: begin
          if (adc_enable && !ctrl[pmm_pkg::snap_pos]) begin
            state     <= pmm_pkg::pmm_conv;
            adc_start <= 1'b1;
            adc_chan  <= cur_ch;
          end else if (adc_enable && snap_go) begin
            state     <= pmm_pkg::pmm_conv;
            adc_start <= 1'b1;
            adc_chan  <= ctrl[pmm_pkg::chsel_pos +: 2];
          end
        end
        pmm_pkg::pmm_conv: begin
          if (!adc_enable) begin
            state <= pmm_pkg::pmm_idle;
          end else if (done_q) begin
            if (ctrl[pmm_pkg::snap_pos]) begin
              state <= pmm_pkg::pmm_idle;
            end else if (cur_ch == pmm_pkg::ch_aux) begin
              state  <= pmm_pkg::pmm_mult;
              cur_ch <= pmm_pkg::ch_sense;
            end else begin
              state  <= pmm_pkg::pmm_idle;
              cur_ch <= cur_ch + 2'h1;
            end
          end
        end
        pmm_pkg::pmm_mult: state <= pmm_pkg::pmm_idle;
        default: state <= pmm_pkg::pmm_idle;
      endcase
    end
  end
  // snapshot request and busy flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      snap_go <= 1'b0;
    end else if (wr_en && wr_addr == pmm_pkg::ctrl_off &&
                 hwdata[pmm_pkg::snap_pos]) begin
      snap_go <= 1'b1;
    end else if (adc_start) begin
      snap_go <= 1'b0;
    end
  end
  // control register; busy is rebuilt every cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl <= pmm_pkg::ctrl_rst;
    end else begin
      if (wr_en && wr_addr == pmm_pkg::ctrl_off) begin
        ctrl <= hwdata[7:0];
      end
      ctrl[pmm_pkg::busy_pos] <= (state == pmm_pkg::pmm_conv) |
                                 snap_go;
    end
  end
  // power operand select and product
  always_comb begin
    case (vsel)
      2'b01:   next_power = 24'(ch[pmm_pkg::ch_sense].code) *
                            24'(ch[pmm_pkg::ch_volt].code);
      2'b10:   next_power = 24'(ch[pmm_pkg::ch_sense].code) *
                            24'(ch[pmm_pkg::ch_aux].code);
      default: next_power = 24'(ch[pmm_pkg::ch_sense].code) *
                            24'(ch[pmm_pkg::ch_volt].code);
    endcase
  end
  // power result, its extremes and thresholds
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      power  <= pmm_pkg::pwr_zero;
      pmax   <= pmm_pkg::pwr_zero;
      pmin   <= pmm_pkg::pwr_ones;
      pthmax <= pmm_pkg::pwr_ones;
      pthmin <= pmm_pkg::pwr_zero;
    end else begin
      if (state == pmm_pkg::pmm_mult) begin
        power <= next_power;
        if (next_power > pmax) begin
          pmax <= next_power;
        end
        if (next_power < pmin) begin
          pmin <= next_power;
        end
      end
      if (wr_en && wr_addr == pmm_pkg::power_off) begin
        power <= hwdata[23:0];
        if (hwdata[23:0] > pmax) begin
          pmax <= hwdata[23:0];
        end
        if (hwdata[23:0] < pmin) begin
          pmin <= hwdata[23:0];
        end
      end
      if (wr_en && wr_addr == pmm_pkg::pmax_off) begin
        pmax <= hwdata[23:0];
      end
      if (wr_en && wr_addr == pmm_pkg::pmin_off) begin
        pmin <= hwdata[23:0];
      end
      if (wr_en && wr_addr == pmm_pkg::pthmax_off) begin
        pthmax <= hwdata[23:0];
      end
      if (wr_en && wr_addr == pmm_pkg::pthmin_off) begin
        pthmin <= hwdata[23:0];
      end
    end
  end
  // per-channel result, extremes and thresholds
  for (genvar c = 0; c < 3; c++) begin : g_ch
    logic        conv_end;
    logic [11:0] nv;
    logic        bus_res;
    // conversion end and bus write share the min/max path
    assign conv_end = state == pmm_pkg::pmm_conv && done_q && adc_enable &&
                      adc_chan == 2'(c);
    assign bus_res  = wr_en && hit(wr_addr, c, pmm_pkg::res_sub);
    assign nv       = bus_res ? hwdata[15:4] : code_q;
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        ch[c].code  <= pmm_pkg::code_zero;
        ch[c].max   <= pmm_pkg::code_zero;
        ch[c].min   <= pmm_pkg::code_ones;
        ch[c].thmax <= pmm_pkg::code_ones;
        ch[c].thmin <= pmm_pkg::code_zero;
      end else begin
        if (conv_end || bus_res) begin
          ch[c].code <= nv;
          if (lt12(ch[c].max, nv)) begin
            ch[c].max <= nv;
          end
          if (lt12(nv, ch[c].min)) begin
            ch[c].min <= nv;
          end
        end
        if (wr_en && hit(wr_addr, c, pmm_pkg::max_sub)) begin
          ch[c].max <= hwdata[15:4];
        end
        if (wr_en && hit(wr_addr, c, pmm_pkg::min_sub)) begin
          ch[c].min <= hwdata[15:4];
        end
        if (wr_en && hit(wr_addr, c, pmm_pkg::thmax_sub)) begin
          ch[c].thmax <= hwdata[15:4];
        end
        if (wr_en && hit(wr_addr, c, pmm_pkg::thmin_sub)) begin
          ch[c].thmin <= hwdata[15:4];
        end
      end
    end
  end
  // window flags per channel and for power, plus mode bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      limit_status <= 10'h000;
    end else begin
      for (int c = 0; c < 3; c++) begin
        limit_status[2*c]   <= lt12(ch[c].code, ch[c].thmin);
        limit_status[2*c+1] <= lt12(ch[c].thmax, ch[c].code);
      end
      limit_status[6]   <= power < pthmin;
      limit_status[7]   <= power > pthmax;
      limit_status[9:8] <= {adc_enable, shdn};
    end
  end
  // read mux
  always_comb begin
    hrdata_c = 32'h0;
    case (rd_addr)
      pmm_pkg::ctrl_off:   hrdata_c = {24'h0, ctrl};
      pmm_pkg::status_off: hrdata_c = {22'h0, limit_status};
      pmm_pkg::power_off:  hrdata_c = {8'h0, power};
      pmm_pkg::pmax_off:   hrdata_c = {8'h0, pmax};
      pmm_pkg::pmin_off:   hrdata_c = {8'h0, pmin};
      pmm_pkg::pthmax_off: hrdata_c = {8'h0, pthmax};
      pmm_pkg::pthmin_off: hrdata_c = {8'h0, pthmin};
      pmm_pkg::addr_off:   hrdata_c = {24'h0, bus_address};
      default: begin
        for (int c = 0; c < 3; c++) begin
          if (hit(rd_addr, c, pmm_pkg::res_sub))
            hrdata_c = {16'h0, ch[c].code, 4'h0};
          if (hit(rd_addr, c, pmm_pkg::max_sub))
            hrdata_c = {16'h0, ch[c].max, 4'h0};
          if (hit(rd_addr, c, pmm_pkg::min_sub))
            hrdata_c = {16'h0, ch[c].min, 4'h0};
          if (hit(rd_addr, c, pmm_pkg::thmax_sub))
            hrdata_c = {16'h0, ch[c].thmax, 4'h0};
          if (hit(rd_addr, c, pmm_pkg::thmin_sub))
            hrdata_c = {16'h0, ch[c].thmin, 4'h0};
        end
      end
    endcase
  end
  // data phase reads the address captured in the address phase
  assign rd_addr = wr_addr;
  assign hrdata  = hrdata_c;
endmodule

// file: verilog/pmm_pkg.sv
// package: constants and types for the power monitor back end
package pmm_pkg;
  localparam logic [7:0] ctrl_off     = 8'h00;
  localparam logic [7:0] status_off   = 8'h04;
  localparam logic [7:0] power_off    = 8'h08;
  localparam logic [7:0] pmax_off     = 8'h0c;
  localparam logic [7:0] pmin_off     = 8'h10;
  localparam logic [7:0] pthmax_off   = 8'h14;
  localparam logic [7:0] pthmin_off   = 8'h18;
  localparam logic [7:0] addr_off     = 8'h1c;
  localparam logic [7:0] chan_base    = 8'h20;
  localparam logic [7:0] chan_stride  = 8'h14;
  localparam logic [7:0] res_sub      = 8'h00;
  localparam logic [7:0] max_sub      = 8'h04;
  localparam logic [7:0] min_sub      = 8'h08;
  localparam logic [7:0] thmax_sub    = 8'h0c;
  localparam logic [7:0] thmin_sub    = 8'h10;
  localparam int         sel_lo_pos   = 0;
  localparam int         shdn_pos     = 1;
  localparam int         sel_hi_pos   = 2;
  localparam int         busy_pos     = 3;
  localparam int         chsel_pos    = 5;
  localparam int         snap_pos     = 7;
  localparam logic [7:0] ctrl_rst     = 8'h05;
  localparam logic [11:0] code_ones   = 12'hfff;
  localparam logic [11:0] code_zero   = 12'h000;
  localparam logic [23:0] pwr_ones    = 24'hffffff;
  localparam logic [23:0] pwr_zero    = 24'h000000;
  localparam logic [1:0] ch_sense     = 2'h0;
  localparam logic [1:0] ch_volt      = 2'h1;
  localparam logic [1:0] ch_aux       = 2'h2;
  typedef enum logic [1:0] {
    pmm_idle = 2'b00,
    pmm_conv = 2'b01,
    pmm_mult = 2'b11
  } pmm_state_t;
  typedef struct packed {
    logic [11:0] code;
    logic [11:0] max;
    logic [11:0] min;
    logic [11:0] thmax;
    logic [11:0] thmin;
  } pmm_chan_t;
  typedef struct packed {
    logic [1:0]  chan;
    logic [11:0] code;
    logic        done;
  } pmm_adc_t;
endpackage

// file: sim/pmm_adc_model.sv
// partner: converter model answering start pulses with delayed codes
`timescale 1ns/1ps
module pmm_adc_model (
  input  wire logic        clk,
  input  wire logic        adc_enable,
  input  wire logic        adc_start,
  input  wire logic [1:0]  adc_chan,
  input  wire logic [35:0] codes,
  input  wire logic [3:0]  dly,
  output logic             adc_done,
  output logic [11:0]      adc_code
);
  logic [4:0]  cnt = 5'h0;
  logic [1:0]  ch  = 2'h0;
  logic [11:0] cur;
  always @(posedge clk) begin
    if (!adc_enable) begin
      cnt <= 5'h0;
    end else if (adc_start) begin
      cnt <= {1'b0, dly} + 5'h3;
      ch  <= adc_chan;
    end else if (cnt != 5'h0) begin
      cnt <= cnt - 5'h1;
    end
  end
  assign cur      = codes[ch * 12 +: 12];
  assign adc_done = (cnt != 5'h0) && (cnt <= 5'h3);
  // outside done the code shows its inverse, so stale data is caught
  assign adc_code = adc_done ? cur : ~cur;
endmodule

// file: sim/pmm_sva.sv
// checker: shutdown, supply lockout and address hold properties
`timescale 1ns/1ps
module pmm_sva (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       vdd_uvlo_ok,
  input wire logic       internal_low_voltage_supply_uvlo_ok,
  input wire logic       vdd_i2c_ok,
  input wire logic       internal_low_voltage_supply_i2c_ok,
  input wire logic       adc_enable,
  input wire logic       adc_start,
  input wire logic       ref_enable,
  input wire logic       regulator_enable,
  input wire logic       iface_rst,
  input wire logic [7:0] bus_address,
  input wire logic [9:0] limit_status
);
  logic sd, any_ok, no_ok, any_if, no_if;
  assign sd     = limit_status[8];
  assign any_ok = vdd_uvlo_ok || internal_low_voltage_supply_uvlo_ok;
  assign no_ok  = !any_ok;
  assign any_if = vdd_i2c_ok || internal_low_voltage_supply_i2c_ok;
  assign no_if  = !any_if;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_reg_off; sd [*4] |-> !regulator_enable; endproperty
  a_reg_off: assert property (p_reg_off)
    else $error("regulator on in shutdown");
  property p_adc_off;
    sd [*4] |-> !adc_enable && !adc_start && !ref_enable;
  endproperty
  a_adc_off: assert property (p_adc_off)
    else $error("converter active in shutdown");
  property p_addr_hold; sd [*4] |-> $stable(bus_address); endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved in shutdown");
  property p_resume; $fell(sd) && any_ok |-> ##[1:8] adc_enable; endproperty
  a_resume: assert property (p_resume)
    else $error("converter not back after shutdown");
  property p_adc_on; (any_ok && !sd) [*6] |-> adc_enable; endproperty
  a_adc_on: assert property (p_adc_on)
    else $error("converter off with a good supply");
  property p_adc_down; no_ok [*5] |-> !adc_enable; endproperty
  a_adc_down: assert property (p_adc_down)
    else $error("converter on with both supplies low");
  property p_if_on; any_if [*5] |-> !iface_rst; endproperty
  a_if_on: assert property (p_if_on)
    else $error("interface held in reset");
  property p_if_rst; no_if [*5] |-> iface_rst; endproperty
  a_if_rst: assert property (p_if_rst)
    else $error("interface not reset");
endmodule

// file: sim/tb.sv
// testbench: bus, scan, shutdown, snapshot and supply scenarios
`timescale 1ns/1ps
module tb;
  logic             clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic [3:0]       sup = 4'hf;
  logic [1:0]       pin_hi = 2'h1;
  logic [1:0]       pin_lo = 2'h0;
  logic [31:0]      haddr = 32'h0;
  logic [1:0]       htrans = 2'h0;
  logic             hwrite = 1'b0;
  logic [31:0]      hwdata = 32'h0;
  logic [2:0][11:0] code;
  logic [3:0]       dly;
  logic [31:0]      hrdata, q, hr_d;
  logic             hr_ok;
  logic             hreadyout, hresp, adc_enable, adc_start, ref_enable;
  logic             regulator_enable, iface_rst, adc_done;
  logic [1:0]       adc_chan;
  logic [7:0]       bus_address;
  logic [9:0]       limit_status;
  logic [11:0]      adc_code, t;
  logic [5:0]       order = 6'h0;
  logic [7:0]       sel_tab [3] = '{8'h05, 8'h01, 8'h04};
  int               starts = 0, err_count = 0, samples_checked = 0, seed;
  always #50 clk = ~clk;
  pmm_top pmm_top_inst (.clk(clk), .sys_rst(sys_rst),
    .vdd_uvlo_ok(sup[3]), .internal_low_voltage_supply_uvlo_ok(sup[2]),
    .vdd_i2c_ok(sup[1]), .internal_low_voltage_supply_i2c_ok(sup[0]),
    .addr_select_pin_hi(pin_hi), .addr_select_pin_lo(pin_lo),
    .adc_done(adc_done), .adc_code(adc_code), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .adc_enable(adc_enable), .adc_start(adc_start),
    .adc_chan(adc_chan), .ref_enable(ref_enable),
    .regulator_enable(regulator_enable), .iface_rst(iface_rst),
    .bus_address(bus_address), .limit_status(limit_status));
  pmm_adc_model pmm_adc_model_inst (.clk(clk), .adc_enable(adc_enable),
    .adc_start(adc_start), .adc_chan(adc_chan), .codes(code), .dly(dly),
    .adc_done(adc_done), .adc_code(adc_code));
  always @(negedge clk) begin
    hr_ok <= hreadyout;
    hr_d  <= hrdata;
    if (adc_start === 1'b1) begin
      starts <= starts + 1;
      if (starts < 3) order <= {order[3:0], adc_chan};
    end
  end
  function automatic logic [31:0] ga(input logic [7:0] o);
    return {24'h0, o};
  endfunction
  function automatic logic [31:0] ca(input int c, input logic [7:0] s);
    return {24'h0, pmm_pkg::chan_base + pmm_pkg::chan_stride * 8'(c) + s};
  endfunction
  function automatic logic [31:0] f(input logic [11:0] x);
    return {16'h0, x, 4'h0};
  endfunction
  function automatic logic [31:0] pw(input logic [11:0] a, b);
    return {8'h0, 24'(a) * 24'(b)};
  endfunction
  task automatic wrap_up;
    if (err_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rdy;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk);
      if (hr_ok === 1'b1) return;
    end
    err_count++;
    wrap_up;
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d,
                      output logic [31:0] r);
    @(posedge clk);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    r = hr_d;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [31:0] a, e, m);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask
  task automatic wait_starts(input int k);
    int e;
    e = starts + k;
    for (int n = 0; starts < e; n++) begin
      if (n > 3000) begin
        err_count++;
        wrap_up;
      end
      @(posedge clk);
    end
  endtask
  initial begin
    seed = 17543;
    for (int c = 0; c < 3; c++) code[c] = 12'($random(seed)) & 12'h7fe;
    code[0] = code[0] | 12'h001;
    dly = 4'($random(seed)) & 4'h7;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rd(ga(pmm_pkg::ctrl_off), 32'h05, 32'hf7);
    rd(ga(pmm_pkg::pthmax_off), 32'h00ffffff, '1);
    rd(ga(pmm_pkg::pthmin_off), 32'h0, '1);
    rd(32'hfc, 32'h0, '1);
    for (int c = 0; c < 3; c++) begin
      rd(ca(c, pmm_pkg::thmax_sub), 32'h0000fff0, '1);
      rd(ca(c, pmm_pkg::thmin_sub), 32'h0, '1);
      t = 12'($random(seed));
      wr(ca(c, pmm_pkg::thmax_sub), f(t));
      rd(ca(c, pmm_pkg::thmax_sub), f(t), '1);
      wr(ca(c, pmm_pkg::thmax_sub), f(12'hfff));
      wr(ca(c, pmm_pkg::min_sub), f(12'hfff));
      wr(ca(c, pmm_pkg::max_sub), 32'h0);
    end
    wait_starts(5);
    chk({26'h0, order}, 32'h06);
    for (int c = 0; c < 3; c++) begin
      rd(ca(c, pmm_pkg::res_sub), f(code[c]), '1);
      rd(ca(c, pmm_pkg::max_sub), f(code[c]), '1);
      rd(ca(c, pmm_pkg::min_sub), f(code[c]), '1);
    end
    wr(ca(0, pmm_pkg::thmax_sub), 32'h0);
    wr(ca(1, pmm_pkg::thmin_sub), f(12'hfff));
    wr(ga(pmm_pkg::pthmin_off), 32'h00ffffff);
    rd(ga(pmm_pkg::status_off), 32'h246, '1);
    wr(ca(0, pmm_pkg::thmax_sub), f(12'hfff));
    wr(ca(1, pmm_pkg::thmin_sub), 32'h0);
    wr(ga(pmm_pkg::pthmin_off), 32'h0);
    rd(ga(pmm_pkg::status_off), 32'h200, '1);
    chk({31'h0, hresp}, 32'h0);
    for (int k = 0; k < 3; k++) begin
      wr(ga(pmm_pkg::ctrl_off), {24'h0, sel_tab[k]});
      wait_starts(5);
      rd(ga(pmm_pkg::power_off),
         pw(code[0], code[1 + k / 2]), '1);
    end
    wr(ga(pmm_pkg::ctrl_off), 32'h06);
    @(posedge clk);
    pin_hi <= 2'h2;
    pin_lo <= 2'h1;
    wr(ca(0, pmm_pkg::res_sub), f(12'hfff));
    wr(ca(0, pmm_pkg::res_sub), 32'h0);
    rd(ca(0, pmm_pkg::max_sub), f(12'hfff), '1);
    rd(ca(0, pmm_pkg::min_sub), 32'h0, '1);
    rd(ca(0, pmm_pkg::res_sub), 32'h0, '1);
    chk({31'h0, regulator_enable}, 32'h0);
    chk({31'h0, ref_enable}, 32'h0);
    chk({24'h0, bus_address}, 32'h04);
    @(posedge clk);
    code[0] <= code[0] ^ 12'h0f0;
    dly <= 4'hf;
    wr(ga(pmm_pkg::ctrl_off), 32'h84);
    q = 32'h8;
    for (int n = 0; n < 40 && (q & 32'h8) !== 32'h0; n++) begin
      xfer(1'b0, ga(pmm_pkg::ctrl_off), 32'h0, q);
    end
    chk(q & 32'h8, 32'h0);
    rd(ca(0, pmm_pkg::res_sub), f(code[0]), '1);
    rd(ga(pmm_pkg::power_off),
       pw(code[0] ^ 12'h0f0, code[2]), '1);
    wr(ga(pmm_pkg::ctrl_off), 32'h04);
    wait_starts(5);
    chk({24'h0, bus_address}, 32'h09);
    rd(ca(0, pmm_pkg::max_sub), f(12'hfff), '1);
    rd(ga(pmm_pkg::power_off), pw(code[0], code[2]), '1);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      sup <= 4'(i);
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk({31'h0, adc_enable}, {31'h0, |sup[3:2]});
      chk({31'h0, iface_rst}, {31'h0, ~|sup[1:0]});
    end
    wrap_up;
  end
endmodule
bind pmm_top pmm_sva pmm_sva_inst (.clk, .sys_rst, .vdd_uvlo_ok,
  .internal_low_voltage_supply_uvlo_ok, .vdd_i2c_ok,
  .internal_low_voltage_supply_i2c_ok, .adc_enable, .adc_start,
  .ref_enable, .regulator_enable, .iface_rst, .bus_address, .limit_status);
